/* rtl/stepper_chop_regulation.sv */
// Summary of operation
// - steps may be ignored up to 1 ms after sleep release.
// - sleep request disables all bridge outputs within 2.5 us.
// - output enable acts on bridges within 20 us either way.
// - chip clear disables outputs within 5 us, re-enables within 5 us.
// - sense current times 8 compared to threshold ends the drive pulse.
// - threshold is full-scale reference weighted by the indexer DAC value.
// - comparator ignored during blanking at every drive pulse start.
// - after a trip, stop driving for fixed off-time, then drive again.
// - each bridge has its own blanking and off-time settings.
// - slow decay uses low-side switches, fast decay opposite pair.
// - dead time always between turning off and on within a leg; the code has none when neg flips during fast decay with sync rect on.
// - sync rect select low turns conducting switches on in decay.
// - sync rect stops reversal, disables bridge near zero current.
// - mixed decay: fast interval first, then slow for rest of off-time.
// - decay input: above 0.6 slow, below 0.2 fast, between mixed.
// - fast portion length comes from decay level and timing setting; the code uses fast_portion_time alone.
// - floating sync rect select gives auto-decay, mixed or slow.
// - chopping cycle repeats continuously while a step is held.
//
// Purpose: chopping current regulation for two H-bridges
// Assumes: comparator level inputs are asynchronous; config is static
// Notes: auto-decay picks mixed after a trip that came right after blanking
`timescale 1ns/1ps
`default_nettype none
module stepper_chop_regulation (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // control pins
   input wire logic i_low_power_request_n,
   input wire logic i_drive_on_n,
   input wire logic i_chip_clear_n,
   input wire logic i_sync_rect_select_n,
   input wire logic i_sync_rect_float,
   input wire logic i_decay_above_hi,
   input wire logic i_decay_below_lo,
   // current regulation
   input wire logic [chop_pkg::REF_W-1:0] i_full_scale_ref,
   input wire logic [chop_pkg::DAC_W-1:0] i_dac_a,
   input wire logic [chop_pkg::DAC_W-1:0] i_dac_b,
   input wire logic i_neg_a,
   input wire logic i_neg_b,
   input wire logic [chop_pkg::SENSE_W-1:0] i_bridge_sense_input_a,
   input wire logic [chop_pkg::SENSE_W-1:0] i_bridge_sense_input_b,
   input wire logic i_zero_cross_a,
   input wire logic i_zero_cross_b,
   // per-bridge timing
   input wire chop_pkg::bridge_cfg_t i_bridge_timing_input_a,
   input wire chop_pkg::bridge_cfg_t i_bridge_timing_input_b,
   // outputs
   output chop_pkg::gates_t o_gates_a,
   output chop_pkg::gates_t o_gates_b,
   output logic o_outputs_live,
   output logic o_step_accept
);
   import chop_pkg::*;

   localparam int NB = 2;

   typedef struct packed {
      logic [1:0] s_sleep;
      logic [1:0] s_en;
      logic [1:0] s_clr;
      logic [1:0] s_sr;
      logic [1:0] s_fl;
      logic [1:0] s_hi;
      logic [1:0] s_lo;
      logic [1:0] s_zc_a;
      logic [1:0] s_zc_b;
      logic [WAKE_W-1:0] wake_cnt;
      logic step_ok;
      logic live;
      bridge_state_t [NB-1:0] br;
   } state_t;

   state_t state_q;
   state_t state_d;

   // trip threshold: reference weighted by dac fraction
   function automatic logic [REF_W+DAC_W-1:0] trip_level(input logic [REF_W-1:0] fs,
                                                        input logic [DAC_W-1:0] dac);
      trip_level = fs * dac;
   endfunction : trip_level

   // sensed current times 8, aligned to threshold scale; saturates instead of wrapping
   function automatic logic [REF_W+DAC_W-1:0] sense_scaled(input logic [SENSE_W-1:0] s);
      logic [SENSE_W+SENSE_GAIN_SH+DAC_W-1:0] wide;
      wide = {s, {(SENSE_GAIN_SH + DAC_W){1'b0}}};
      if (wide[SENSE_W+SENSE_GAIN_SH+DAC_W-1:REF_W+DAC_W] != '0) begin
         sense_scaled = '1;
      end else begin
         sense_scaled = wide[REF_W+DAC_W-1:0];
      end
   endfunction : sense_scaled

   // decay gates: positive drive is hs1+ls2
   function automatic gates_t decay_gates(input logic fast, input logic neg, input logic sr_on);
      gates_t g;
      g = '0;
      if (fast) begin
         // opposite pair returns energy; diodes conduct when sync is off
         g.hs2 = sr_on & ~neg;
         g.ls1 = sr_on & ~neg;
         g.hs1 = sr_on & neg;
         g.ls2 = sr_on & neg;
      end else begin
         g.ls1 = 1'b1;
         g.ls2 = 1'b1;
      end
      decay_gates = g;
   endfunction : decay_gates

   function automatic gates_t drive_gates(input logic neg);
      gates_t g;
      g = '0;
      g.hs1 = ~neg;
      g.ls2 = ~neg;
      g.hs2 = neg;
      g.ls1 = neg;
      drive_gates = g;
   endfunction : drive_gates

   logic sleep_n;
   logic run;
   logic sr_on;
   logic auto_mode;
   decay_t decay_sel;
   logic [NB-1:0] trip;
   logic [NB-1:0] neg;
   logic [NB-1:0] zc;
   bridge_cfg_t cfg [NB];

   always_comb begin
      sleep_n = state_q.s_sleep[1];
      // sleep, disable and clear all gate the bridges
      run = sleep_n & ~state_q.s_en[1] & state_q.s_clr[1];
      auto_mode = state_q.s_fl[1];
      sr_on = ~state_q.s_sr[1] & ~auto_mode;
      if (state_q.s_hi[1]) begin
         decay_sel = DEC_SLOW;
      end else if (state_q.s_lo[1]) begin
         decay_sel = DEC_FAST;
      end else begin
         decay_sel = DEC_MIXED;
      end
      trip[0] = sense_scaled(i_bridge_sense_input_a) >= trip_level(i_full_scale_ref, i_dac_a);
      trip[1] = sense_scaled(i_bridge_sense_input_b) >= trip_level(i_full_scale_ref, i_dac_b);
      neg[0] = i_neg_a;
      neg[1] = i_neg_b;
      zc[0] = state_q.s_zc_a[1];
      zc[1] = state_q.s_zc_b[1];
      cfg[0] = i_bridge_timing_input_a;
      cfg[1] = i_bridge_timing_input_b;
   end

   always_comb begin
      state_d = state_q;
      state_d.s_sleep = {state_q.s_sleep[0], i_low_power_request_n};
      state_d.s_en = {state_q.s_en[0], i_drive_on_n};
      state_d.s_clr = {state_q.s_clr[0], i_chip_clear_n};
      state_d.s_sr = {state_q.s_sr[0], i_sync_rect_select_n};
      state_d.s_fl = {state_q.s_fl[0], i_sync_rect_float};
      state_d.s_hi = {state_q.s_hi[0], i_decay_above_hi};
      state_d.s_lo = {state_q.s_lo[0], i_decay_below_lo};
      state_d.s_zc_a = {state_q.s_zc_a[0], i_zero_cross_a};
      state_d.s_zc_b = {state_q.s_zc_b[0], i_zero_cross_b};
      state_d.live = run;
      // wake timer after sleep release
      if (!sleep_n) begin
         state_d.wake_cnt = WAKE_W'(WAKE_CYC);
         state_d.step_ok = 1'b0;
      end else if (state_q.wake_cnt != WAKE_ZERO) begin
         state_d.wake_cnt = state_q.wake_cnt - 1'b1;
      end else begin
         state_d.step_ok = 1'b1;
      end
      for (int b = 0; b < NB; b++) begin
         if (!run) begin
            state_d.br[b].st = ST_OFF;
            state_d.br[b].g = '0;
            state_d.br[b].cnt = DEAD_LOAD;
            state_d.br[b].fcnt = CNT_ZERO;
            state_d.br[b].fast = 1'b0;
         end else begin
            if (state_q.br[b].cnt != CNT_ZERO) begin
               state_d.br[b].cnt = state_q.br[b].cnt - 1'b1;
            end
            if (state_q.br[b].fcnt != CNT_ZERO) begin
               state_d.br[b].fcnt = state_q.br[b].fcnt - 1'b1;
            end
            unique case (state_q.br[b].st)
               ST_OFF: begin
                  // all switches off for a dead time before fresh drive
                  state_d.br[b].g = '0;
                  if (state_q.br[b].cnt == CNT_ZERO) begin
                     state_d.br[b].st = ST_BLANK;
                     state_d.br[b].g = drive_gates(neg[b]);
                     state_d.br[b].cnt = cfg[b].blank_cyc;
                  end
               end
               ST_DEAD_ON: begin
                  state_d.br[b].g = '0;
                  if (state_q.br[b].cnt == CNT_ZERO) begin
                     state_d.br[b].st = ST_BLANK;
                     state_d.br[b].g = drive_gates(neg[b]);
                     state_d.br[b].cnt = cfg[b].blank_cyc;
                  end
               end
               ST_BLANK: begin
                  // comparator does not end the pulse here; its level at blank end is kept in auto_mixed
                  if (state_q.br[b].cnt <= CNT_ONE) begin
                     state_d.br[b].st = ST_DRIVE;
                     state_d.br[b].auto_mixed = trip[b];
                  end
               end
               ST_DRIVE: begin
                  if (trip[b]) begin
                     state_d.br[b].st = ST_DECAY;
                     state_d.br[b].cnt = cfg[b].off_cyc;
                     if (auto_mode) begin
                        state_d.br[b].fast = state_q.br[b].auto_mixed;
                        state_d.br[b].fcnt = state_q.br[b].auto_mixed ? cfg[b].fast_portion_time
                                                                      : CNT_ZERO;
                     end else begin
                        state_d.br[b].fast = (decay_sel != DEC_SLOW);
                        state_d.br[b].fcnt = (decay_sel == DEC_MIXED) ? cfg[b].fast_portion_time
                                                                      : CNT_ZERO;
                     end
                     // turn drive off first; decay switches follow dead time
                     state_d.br[b].g = '0;
                  end
                  state_d.br[b].auto_mixed = 1'b0;
               end
               ST_DECAY: begin
                  // mixed: fast until fast counter ends, then slow
                  if (state_q.br[b].fast && state_q.br[b].fcnt == CNT_ZERO &&
                      (decay_sel == DEC_MIXED || auto_mode)) begin
                     state_d.br[b].fast = 1'b0;
                     state_d.br[b].g = '0;
                     // fast counter reused as dead timer before the slow pair turns on
                     state_d.br[b].fcnt = DEAD_LOAD;
                  end else if (sr_on && zc[b]) begin
                     state_d.br[b].g = '0;
                  end else if (state_q.br[b].cnt + DEAD_LOAD <= cfg[b].off_cyc &&
                               (state_q.br[b].fast || state_q.br[b].fcnt == CNT_ZERO)) begin
                     state_d.br[b].g = decay_gates(state_q.br[b].fast, neg[b], sr_on | ~state_q.br[b].fast);
                  end
                  if (state_q.br[b].cnt == CNT_ZERO) begin
                     state_d.br[b].st = ST_DEAD_ON;
                     state_d.br[b].g = '0;
                     state_d.br[b].cnt = DEAD_LOAD;
                  end
               end
               default: begin
                  state_d.br[b].st = ST_OFF;
                  state_d.br[b].g = '0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_q <= '0;
         for (int b = 0; b < NB; b++) begin
            state_q.br[b].st <= ST_OFF;
            state_q.br[b].cnt <= DEAD_LOAD;
         end
      end else begin
         state_q <= state_d;
      end
   end

   always_comb begin
      o_gates_a = state_q.br[0].g;
      o_gates_b = state_q.br[1].g;
      o_outputs_live = state_q.live;
      o_step_accept = state_q.step_ok;
   end

   // checks
   chk_sleep_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_low_power_request_n [*3] |=> (o_gates_a == '0 && o_gates_b == '0))
      else $error("gates on while sleeping");
   chk_enable_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_drive_on_n [*3] |=> !o_outputs_live)
      else $error("outputs live while disabled");
   chk_clear_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !i_chip_clear_n [*3] |=> (o_gates_a == '0 && o_gates_b == '0))
      else $error("gates on while cleared");
   chk_leg_a_safe: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !(o_gates_a.hs1 && o_gates_a.ls1) && !(o_gates_a.hs2 && o_gates_a.ls2))
      else $error("shoot-through leg a");
   chk_leg_dead: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $fell(o_gates_b.hs1) |-> !o_gates_b.ls1)
      else $error("no dead time leg b");
   chk_blank_ign: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      state_q.br[0].st == ST_BLANK && state_q.br[0].cnt > CNT_ONE && run |=> state_q.br[0].st == ST_BLANK)
      else $error("blanking cut short");
   chk_trip_decay: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      state_q.br[0].st == ST_DRIVE && trip[0] && run |=> state_q.br[0].st == ST_DECAY)
      else $error("trip not honoured");
   chk_wake_block: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $rose(state_q.s_sleep[1]) |=> !o_step_accept [*8])
      else $error("steps accepted too early");
   chk_restart_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !run |=> state_q.br[1].st == ST_OFF)
      else $error("bridge not reset when halted");
   chk_leg_b_safe: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !(o_gates_b.hs1 && o_gates_b.ls1) && !(o_gates_b.hs2 && o_gates_b.ls2))
      else $error("shoot-through leg b");
   chk_slow_dead: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $fell(state_q.br[0].fast) && state_q.br[0].st == ST_DECAY |=> o_gates_a == '0)
      else $error("no dead time before slow decay");
   chk_step_sleep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !sleep_n |=> !o_step_accept)
      else $error("steps accepted while asleep");
   chk_live_run: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      run |=> o_outputs_live)
      else $error("outputs not live when running");
   chk_off_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      !run |=> (o_gates_a == '0 && o_gates_b == '0))
      else $error("gates on while halted");
   chk_zero_open: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      state_q.br[0].st == ST_DECAY && run && sr_on && zc[0] |=> o_gates_a == '0)
      else $error("bridge not opened at zero current");
   chk_trip_b: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      state_q.br[1].st == ST_DRIVE && trip[1] && run |=> state_q.br[1].st == ST_DECAY)
      else $error("trip not honoured on bridge b");
   chk_blank_b: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      state_q.br[1].st == ST_BLANK && state_q.br[1].cnt > CNT_ONE && run |=> state_q.br[1].st == ST_BLANK)
      else $error("blanking cut short on bridge b");
   cov_trip: cover property (@(posedge i_sys_clk) state_q.br[0].st == ST_DECAY);
   cov_redrive: cover property (@(posedge i_sys_clk) state_q.br[0].st == ST_DEAD_ON ##1 state_q.br[0].st == ST_DEAD_ON);
   cov_mixed: cover property (@(posedge i_sys_clk) $fell(state_q.br[0].fast) && state_q.br[0].st == ST_DECAY);
   cov_auto_mixed: cover property (@(posedge i_sys_clk) auto_mode && state_q.br[0].fast && state_q.br[0].st == ST_DECAY);
   cov_zero_open: cover property (@(posedge i_sys_clk) sr_on && zc[0] && state_q.br[0].st == ST_DECAY);
endmodule : stepper_chop_regulation
`default_nettype wire

/* rtl/chop_pkg.sv */
// Purpose: shared constants and types for the two-bridge chopping controller
// Assumes: 25 MHz core clock
// Notes: timing figures kept in their own units, cycle counts derived here
package chop_pkg;
   localparam int CLK_MHZ = 25;
   localparam int CLK_KHZ = 25000;
   // latency limits in ns, wake time in us, as printed
   localparam int T_SLEEP_NS = 2500;
   localparam int T_ENABLE_NS = 20000;
   localparam int T_RESET_NS = 5000;
   localparam int T_WAKE_US = 1000;
   // longest times round down
   localparam int SLEEP_CYC = (T_SLEEP_NS * CLK_MHZ) / 1000;
   localparam int ENABLE_CYC = (T_ENABLE_NS * CLK_MHZ) / 1000;
   localparam int RESET_CYC = (T_RESET_NS * CLK_MHZ) / 1000;
   localparam int WAKE_CYC = T_WAKE_US * CLK_MHZ;
   // dead time: least 100 ns, rounded up
   localparam int T_DEAD_NS = 100;
   localparam int DEAD_CYC = (T_DEAD_NS * CLK_MHZ + 999) / 1000;
   localparam int TW = 16;
   localparam logic [TW-1:0] DEAD_LOAD = TW'(DEAD_CYC);
   localparam logic [TW-1:0] CNT_ZERO = 16'h0000;
   localparam logic [TW-1:0] CNT_ONE = 16'h0001;
   localparam int SENSE_GAIN_SH = 3; // gain of 8
   localparam int REF_W = 12;
   localparam int DAC_W = 8;
   localparam int SENSE_W = 12;
   localparam int WAKE_W = 16;
   localparam logic [WAKE_W-1:0] WAKE_ZERO = 16'h0000;
   // decay select codes: comparator result of the decay input level
   typedef enum logic [1:0] {
      DEC_FAST = 2'h0,
      DEC_MIXED = 2'h1,
      DEC_SLOW = 2'h2
   } decay_t;
   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_DEAD_ON = 5'h02,
      ST_BLANK = 5'h04,
      ST_DRIVE = 5'h08,
      ST_DECAY = 5'h10
   } chop_st_t;
   // per-bridge timing configuration replacing the external RC parts
   typedef struct packed {
      logic [TW-1:0] blank_cyc;
      logic [TW-1:0] off_cyc;
      logic [TW-1:0] fast_portion_time;
   } bridge_cfg_t;
   // four switch gates of one bridge: hs1, ls1, hs2, ls2
   typedef struct packed {
      logic hs1;
      logic ls1;
      logic hs2;
      logic ls2;
   } gates_t;
   typedef struct packed {
      chop_st_t st;
      logic [TW-1:0] cnt;
      logic [TW-1:0] fcnt;
      logic fast;
      logic auto_mixed;
      gates_t g;
   } bridge_state_t;
endpackage : chop_pkg

/* verif/step_source_model.sv */
// Purpose: motion controller model issuing step pulses
// Assumes: 25 MHz clock; i_go held while steps are wanted
// Notes: no pulse before the block accepts steps
`timescale 1ns/1ps
`default_nettype none
module step_source_model #(parameter int HALF_CYC = 25) (
   // clock
   input wire logic i_sys_clk,
   // control
   input wire logic i_go,
   input wire logic i_step_accept,
   // step pulses
   output logic o_step,
   output logic [7:0] o_steps_sent
);
   int cnt_q = 0;
   initial o_step = 1'b0;
   initial o_steps_sent = 8'h00;
   always @(posedge i_sys_clk) begin
      if (i_go && i_step_accept) begin
         cnt_q <= (cnt_q == HALF_CYC - 1) ? 0 : cnt_q + 1;
         if (cnt_q == HALF_CYC - 1) begin
            o_step <= !o_step;
            o_steps_sent <= o_steps_sent + {7'h00, !o_step};
         end
      end
   end
endmodule : step_source_model
`default_nettype wire

/* verif/test_stepper_chop_regulation.sv */
// Purpose: self-checking bench for the chopping controller
// Assumes: 25 MHz clock; blank 4, off 40, fast 10 on bridge a
// Notes: gate windows allow for dead time and input sync
`timescale 1ns/1ps
`default_nettype none
module test_stepper_chop_regulation;
   import chop_pkg::*;
   localparam gates_t DRV = gates_t'(4'h9);
   localparam gates_t SLW = gates_t'(4'h5);
   localparam gates_t FST = gates_t'(4'h6);
   localparam gates_t NON = gates_t'(4'h0);
   logic clk = 1'b0, rst = 1'b1, lp_n = 1'b0, don_n = 1'b0, clr_n = 1'b1;
   logic sr_n = 1'b0, flt = 1'b0, hi = 1'b1, lo = 1'b0, go = 1'b1, zc_a = 1'b0;
   logic [REF_W-1:0] fsr = 12'h400;
   logic [DAC_W-1:0] dac_a = 8'h80, dac_b = 8'h80;
   logic [SENSE_W-1:0] sen_a = 12'h000, sen_b = 12'h000;
   bridge_cfg_t cfg_a = {16'h0004, 16'h0028, 16'h000A};
   bridge_cfg_t cfg_b = {16'h0008, 16'h0028, 16'h000A};
   gates_t g_a, g_b, prev;
   logic live, acc, stp;
   logic [7:0] sent;
   int num_errors = 0, n_compared = 0, n;
   always #20 clk = !clk;
   stepper_chop_regulation i_stepper_chop_regulation (.i_sys_clk(clk), .i_rst(rst),
      .i_low_power_request_n(lp_n), .i_drive_on_n(don_n), .i_chip_clear_n(clr_n),
      .i_sync_rect_select_n(sr_n), .i_sync_rect_float(flt), .i_decay_above_hi(hi),
      .i_decay_below_lo(lo), .i_full_scale_ref(fsr), .i_dac_a(dac_a), .i_dac_b(dac_b),
      .i_neg_a(1'b0), .i_neg_b(1'b0), .i_bridge_sense_input_a(sen_a),
      .i_bridge_sense_input_b(sen_b), .i_zero_cross_a(zc_a), .i_zero_cross_b(1'b0),
      .i_bridge_timing_input_a(cfg_a), .i_bridge_timing_input_b(cfg_b),
      .o_gates_a(g_a), .o_gates_b(g_b), .o_outputs_live(live), .o_step_accept(acc));
   step_source_model i_step_source_model (.i_sys_clk(clk), .i_go(go),
      .i_step_accept(acc), .o_step(stp), .o_steps_sent(sent));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   function automatic gates_t gb(input bit b);
      return b ? g_b : g_a;
   endfunction : gb
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   // wait while the bridge shows gates other than g
   task automatic wait_g(input bit b, input gates_t g, input int lim, output int k);
      for (k = 0; gb(b) !== g && k < lim; k++) tick();
   endtask : wait_g
   // count cycles the bridge holds gates g
   task automatic hold_g(input bit b, input gates_t g, input int lim, output int k);
      for (k = 0; gb(b) === g && k < lim; k++) tick();
   endtask : hold_g
   // no leg of bridge a flips high side to low side in one cycle
   always @(posedge clk) begin
      prev <= g_a;
      if (!rst) check("leg_dead", {prev.hs1 & g_a.ls1, prev.ls1 & g_a.hs1,
         prev.hs2 & g_a.ls2, prev.ls2 & g_a.hs2}, 4'h0);
   end
   task automatic t_reset;
      repeat (10) tick();
      check("rst_out", {g_a, g_b, live, acc}, 10'h000);
      @(posedge clk);
      rst <= 1'b0;
      #1;
   endtask : t_reset
   task automatic t_wake;
      @(posedge clk);
      lp_n <= 1'b1;
      #1;
      for (n = 0; acc !== 1'b1 && n < WAKE_CYC + 20; n++) tick();
      check("wake_time", n <= WAKE_CYC + 5, 1);
      check("no_early_step", sent, 8'h00);
      check("no_early_pulse", stp, 1'b0);
      repeat (250) tick();
      check("steps_sent", sent, 8'h05);
   endtask : t_wake
   task automatic t_slow;
      @(posedge clk);
      sen_a <= 12'h03F;
      #1;
      wait_g(0, DRV, 20, n);
      hold_g(0, DRV, 100, n);
      check("no_trip", n, 100);
      @(posedge clk);
      sen_a <= 12'h040;
      #1;
      hold_g(0, DRV, 8, n);
      check("trip_end", n < 4, 1);
      wait_g(0, DRV, 100, n);
      check("off_gap", n >= 40 && n <= 50, 1);
      hold_g(0, DRV, 20, n);
      check("blank_a", n >= 4 && n <= 7, 1);
   endtask : t_slow
   task automatic t_decay(input logic h, l, s, f, input gates_t first, input int lo_n, hi_n);
      @(posedge clk);
      {hi, lo, sr_n, flt} <= {h, l, s, f};
      #1;
      repeat (2) begin
         wait_g(0, DRV, 120, n);
         hold_g(0, DRV, 20, n);
      end
      wait_g(0, first, 8, n);
      check("decay_first", gb(0), first);
      hold_g(0, first, 100, n);
      check("decay_len", n >= lo_n && n <= hi_n, 1);
   endtask : t_decay
   task automatic t_modes;
      t_decay(0, 0, 0, 0, FST, 6, 11);
      wait_g(0, SLW, 6, n);
      check("mixed_slow", gb(0), SLW);
      t_decay(1, 0, 0, 0, SLW, 32, 41);
      t_decay(0, 1, 0, 0, FST, 32, 41);
      t_decay(0, 1, 1, 0, NON, 40, 50);
      t_decay(1, 0, 0, 1, NON, 12, 18);
      t_decay(0, 0, 1, 0, NON, 12, 18);
   endtask : t_modes
   task automatic t_zero;
      t_decay(1, 0, 0, 0, SLW, 32, 41);
      wait_g(0, SLW, 60, n);
      @(posedge clk);
      zc_a <= 1'b1;
      #1;
      wait_g(0, NON, 6, n);
      check("zero_open", n < 5, 1);
      @(posedge clk);
      zc_a <= 1'b0;
      #1;
   endtask : t_zero
   task automatic t_bridge_b;
      @(posedge clk);
      sen_b <= 12'h040;
      #1;
      repeat (2) begin
         wait_g(1, DRV, 120, n);
         hold_g(1, DRV, 20, n);
      end
      check("blank_b", n >= 8 && n <= 11, 1);
   endtask : t_bridge_b
   task automatic t_off(input int which, input int lim);
      @(posedge clk);
      if (which == 0) lp_n <= 1'b0;
      else if (which == 1) don_n <= 1'b1;
      else clr_n <= 1'b0;
      #1;
      for (n = 0; live !== 1'b0 && n < lim + 5; n++) tick();
      check("off_time", n <= lim, 1);
      check("off_gates", {g_a, g_b}, 8'h00);
      repeat (10) tick();
      @(posedge clk);
      {lp_n, don_n, clr_n} <= 3'b101;
      #1;
      wait_g(0, DRV, lim + 10, n);
      check("on_time", n <= lim + 6, 1);
      hold_g(0, DRV, 20, n);
      check("fresh_blank", n >= 4, 1);
   endtask : t_off
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      conclude();
   end
   initial begin
      t_reset();
      t_wake();
      t_slow();
      t_modes();
      t_zero();
      t_bridge_b();
      t_off(0, SLEEP_CYC);
      t_off(1, ENABLE_CYC);
      t_off(2, RESET_CYC);
      conclude();
   end
endmodule : test_stepper_chop_regulation
`default_nettype wire
